// file: design/pwcs_pkg.sv
// Purpose: shared constants for the paged window chip select block
// Assumes: 16-bit core address, six-bit page index
// Notes: allocation codes select the flash size decode
`default_nettype none
package pwcs_pkg;
    localparam int ADDR_W = 16;
    localparam int PAGE_W = 6;
    // address quadrant taken from the two top address bits
    localparam logic [1:0] QUAD_LOW = 2'h0;
    localparam logic [1:0] QUAD_MID = 2'h1;
    localparam logic [1:0] QUAD_WIN = 2'h2;
    localparam logic [1:0] QUAD_TOP = 2'h3;
    // extended address constants outside the window
    localparam logic [5:0] XA_LOW = 6'h3D;
    localparam logic [5:0] XA_MID = 6'h3E;
    localparam logic [5:0] XA_TOP = 6'h3F;
    // highest external page per partition setting
    localparam logic [5:0] EXT_MAX_SW0 = 6'h37;
    localparam logic [5:0] EXT_MAX_SW1 = 6'h2F;
    localparam logic [5:0] EXT_MAX_SW2 = 6'h1F;
    localparam logic [1:0] SW_FULL = 2'h3;
    // allocated physical flash size codes
    localparam logic [1:0] ALLOC_0K = 2'h0;
    localparam logic [1:0] ALLOC_16K = 2'h1;
    localparam logic [1:0] ALLOC_48K = 2'h2;
    localparam logic [1:0] ALLOC_64K = 2'h3;
    localparam logic [5:0] PAGE_RESET = 6'h00;
    localparam logic [15:0] ADDR_RESET = 16'h0000;
    // paged call / return sequencer states, one-hot
    typedef enum logic [3:0] {
        SEQ_IDLE = 4'h1,
        SEQ_LOAD = 4'h2,
        SEQ_PUSH = 4'h4,
        SEQ_DONE = 4'h8
    } pwcs_seq_t;
endpackage : pwcs_pkg
`default_nettype wire

// file: design/pwcs_window_decode.sv
// Purpose: combinational decode of page window internal/external split
// Assumes: partition switches are static
// Notes: instantiated by the main block
`default_nettype none
module pwcs_window_decode (
    // inputs
    input wire logic [5:0] page,
    input wire logic [1:0] paging_partition_switches,
    // result
    output logic page_external
);
    always_comb begin
        case (paging_partition_switches)
            2'h0: page_external = (page <= pwcs_pkg::EXT_MAX_SW0);
            2'h1: page_external = (page <= pwcs_pkg::EXT_MAX_SW1);
            2'h2: page_external = (page <= pwcs_pkg::EXT_MAX_SW2);
            default: page_external = 1'b0;
        endcase
    end
endmodule : pwcs_window_decode
`default_nettype wire

// file: design/pwcs_top.sv
// Purpose: program page register, extended address and chip selects
// Assumes: core bus signals are synchronous to clock
// Notes: address and select outputs are registered so address and selects move together
`default_nettype none
module pwcs_top (
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // mode and integration
    input wire logic port_k_expansion_enable,
    input wire logic expanded_mode,
    input wire logic emulation_mode,
    input wire logic [1:0] paging_partition_switches,
    input wire logic [1:0] flash_allocation,
    input wire logic page_write_allowed,
    // miscellaneous control write
    input wire logic misc_write,
    input wire logic misc_rom_hide_data,
    // core bus
    input wire logic bus_valid,
    input wire logic [15:0] bus_address,
    input wire logic bus_internal_hit,
    input wire logic bus_unmapped,
    // ordinary page register access
    input wire logic page_write,
    input wire logic [5:0] page_write_data,
    // paged call and return
    input wire logic call_start,
    input wire logic return_start,
    input wire logic [5:0] call_page_immediate,
    input wire logic call_indirect,
    input wire logic [5:0] call_page_memory,
    input wire logic [5:0] return_page_pulled,
    // stack interface
    output logic push_valid,
    output logic [5:0] push_page,
    output logic seq_busy,
    output logic interrupt_block,
    // page register state
    output logic [5:0] program_page_register,
    output logic rom_hide_in_map,
    output logic page_window_access,
    // port k pins
    output logic [5:0] extended_address_out,
    output logic emulation_chip_select_n,
    output logic external_chip_select_n,
    output logic port_k_pin_override
);
    ////////////////////////////////////////////////////////////////////////
    pwcs_pkg::pwcs_seq_t state;
    pwcs_pkg::pwcs_seq_t next_state;
    logic is_call;
    logic [5:0] saved_page;
    logic [5:0] new_page;
    logic page_external;
    logic [1:0] quad;
    logic in_window;
    logic flash_hit;
    logic next_ecs_n;
    logic next_xcs_n;
    logic [5:0] next_xa;

    // immediate operand unless indexed-indirect
    assign new_page = call_indirect ? call_page_memory : call_page_immediate;

    always_comb begin
        next_state = state;
        case (state)
            pwcs_pkg::SEQ_IDLE: begin
                if (call_start || return_start) begin
                    next_state = pwcs_pkg::SEQ_LOAD;
                end
            end
            pwcs_pkg::SEQ_LOAD: next_state = pwcs_pkg::SEQ_PUSH;
            pwcs_pkg::SEQ_PUSH: next_state = pwcs_pkg::SEQ_DONE;
            pwcs_pkg::SEQ_DONE: next_state = pwcs_pkg::SEQ_IDLE;
            default: next_state = pwcs_pkg::SEQ_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state <= pwcs_pkg::SEQ_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            is_call <= 1'b0;
            saved_page <= pwcs_pkg::PAGE_RESET;
        end else if (state == pwcs_pkg::SEQ_IDLE && (call_start || return_start)) begin
            is_call <= call_start;
            saved_page <= program_page_register;
        end
    end

    // sequence busy masks interrupts from start to end
    assign seq_busy = (state != pwcs_pkg::SEQ_IDLE);
    assign interrupt_block = seq_busy;
    // old page pushed after the core pushes the return address
    assign push_valid = is_call && (state == pwcs_pkg::SEQ_PUSH);
    assign push_page = saved_page;

    ////////////////////////////////////////////////////////////////////////
    // page register: sequence writes beat plain writes
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            program_page_register <= pwcs_pkg::PAGE_RESET;
        end else if (state == pwcs_pkg::SEQ_IDLE && call_start) begin
            program_page_register <= new_page;
        end else if (state == pwcs_pkg::SEQ_DONE && !is_call) begin
            program_page_register <= return_page_pulled;
        end else if (!seq_busy && page_write && page_write_allowed) begin
            program_page_register <= page_write_data;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rom_hide_in_map <= 1'b0;
        end else if (misc_write) begin
            rom_hide_in_map <= misc_rom_hide_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    pwcs_window_decode u_decode (
        .page(program_page_register),
        .paging_partition_switches(paging_partition_switches),
        .page_external(page_external)
    );

    assign quad = bus_address[15:14];
    assign in_window = (quad == pwcs_pkg::QUAD_WIN);

    always_comb begin
        case (quad)
            pwcs_pkg::QUAD_LOW: next_xa = pwcs_pkg::XA_LOW;
            pwcs_pkg::QUAD_MID: next_xa = pwcs_pkg::XA_MID;
            pwcs_pkg::QUAD_WIN: next_xa = program_page_register;
            default: next_xa = pwcs_pkg::XA_TOP;
        endcase
    end

    // flash space per allocated size
    always_comb begin
        flash_hit = 1'b0;
        case (flash_allocation)
            pwcs_pkg::ALLOC_0K: flash_hit = quad[1];
            pwcs_pkg::ALLOC_16K: flash_hit = (quad == pwcs_pkg::QUAD_TOP);
            pwcs_pkg::ALLOC_48K: begin
                case (quad)
                    pwcs_pkg::QUAD_MID: flash_hit = !rom_hide_in_map;
                    pwcs_pkg::QUAD_WIN: flash_hit = !page_external;
                    pwcs_pkg::QUAD_TOP: flash_hit = 1'b1;
                    default: flash_hit = 1'b0;
                endcase
            end
            default: begin
                case (quad)
                    pwcs_pkg::QUAD_WIN: flash_hit = !page_external;
                    pwcs_pkg::QUAD_TOP: flash_hit = 1'b1;
                    default: flash_hit = !rom_hide_in_map;
                endcase
            end
        endcase
    end

    always_comb begin
        next_ecs_n = !(bus_valid && emulation_mode && expanded_mode
                       && port_k_expansion_enable && flash_hit);
        // external only when not internal, mapped, and no emulation select
        next_xcs_n = !(bus_valid && expanded_mode && port_k_expansion_enable
                       && next_ecs_n && !bus_internal_hit && !bus_unmapped);
    end

    ////////////////////////////////////////////////////////////////////////
    // one registered sample keeps lines and selects aligned
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            extended_address_out <= pwcs_pkg::XA_LOW;
            emulation_chip_select_n <= 1'b1;
            external_chip_select_n <= 1'b1;
            page_window_access <= 1'b0;
        end else begin
            extended_address_out <= next_xa;
            emulation_chip_select_n <= next_ecs_n;
            external_chip_select_n <= next_xcs_n;
            page_window_access <= bus_valid && in_window;
        end
    end

    // pin mux: disabled expansion hands pins back to general purpose
    assign port_k_pin_override = port_k_expansion_enable && expanded_mode;

    ////////////////////////////////////////////////////////////////////////
    property p_xcs_excl;
        @(posedge clock) disable iff (!reset_n)
        !emulation_chip_select_n |-> external_chip_select_n;
    endproperty
    a_xcs_excl: assert property (p_xcs_excl) else $error("both selects low");

    property p_ecs_enable;
        @(posedge clock) disable iff (!reset_n)
        (!port_k_expansion_enable || !emulation_mode) |=> emulation_chip_select_n;
    endproperty
    a_ecs_enable: assert property (p_ecs_enable) else $error("ecs without mode");

    property p_unmapped;
        @(posedge clock) disable iff (!reset_n)
        (bus_unmapped || bus_internal_hit) |=> external_chip_select_n;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("xcs on removed space");

    property p_window_xa;
        @(posedge clock) disable iff (!reset_n)
        (bus_address[15:14] == 2'h2 && !seq_busy && !call_start && !return_start)
            |=> extended_address_out == $past(program_page_register);
    endproperty
    a_window_xa: assert property (p_window_xa) else $error("window page wrong");

    property p_top_xa;
        @(posedge clock) disable iff (!reset_n)
        bus_address[15:14] == 2'h3 |=> extended_address_out == 6'h3F;
    endproperty
    a_top_xa: assert property (p_top_xa) else $error("top constant wrong");

    property p_low_xa;
        @(posedge clock) disable iff (!reset_n)
        bus_address[15:14] == 2'h0 |=> extended_address_out == 6'h3D;
    endproperty
    a_low_xa: assert property (p_low_xa) else $error("low constant wrong");

    property p_plain_write;
        @(posedge clock) disable iff (!reset_n)
        (!seq_busy && !call_start && !return_start && page_write && page_write_allowed)
            |=> program_page_register == $past(page_write_data);
    endproperty
    a_plain_write: assert property (p_plain_write) else $error("page write lost");

    property p_call_seq;
        @(posedge clock) disable iff (!reset_n)
        (!seq_busy && call_start) |=> interrupt_block [*3] ##1 !interrupt_block;
    endproperty
    a_call_seq: assert property (p_call_seq) else $error("call not atomic");

    property p_call_push;
        @(posedge clock) disable iff (!reset_n)
        (!seq_busy && call_start)
            |=> ##1 (push_valid && push_page == $past(program_page_register, 2));
    endproperty
    a_call_push: assert property (p_call_push) else $error("old page not pushed");

    property p_16k;
        @(posedge clock) disable iff (!reset_n)
        (flash_allocation == 2'h1 && bus_address[15:14] != 2'h3) |=> emulation_chip_select_n;
    endproperty
    a_16k: assert property (p_16k) else $error("16K select wrong");

    property p_mid_xa;
        @(posedge clock) disable iff (!reset_n)
        bus_address[15:14] == pwcs_pkg::QUAD_MID |=> extended_address_out == 6'h3E;
    endproperty
    a_mid_xa: assert property (p_mid_xa) else $error("mid constant wrong");

    // pulled page must be in the register once the return sequence ends
    property p_return_page;
        @(posedge clock) disable iff (!reset_n)
        (!seq_busy && return_start)
            |=> ##3 program_page_register == $past(return_page_pulled);
    endproperty
    a_return_page: assert property (p_return_page) else $error("return page lost");

    c_call: cover property (@(posedge clock) disable iff (!reset_n) push_valid);
    c_ecs: cover property (@(posedge clock) disable iff (!reset_n) !emulation_chip_select_n);
    c_xcs: cover property (@(posedge clock) disable iff (!reset_n) !external_chip_select_n);
    c_ret: cover property (@(posedge clock) disable iff (!reset_n)
        return_start && !seq_busy ##4 !seq_busy);
endmodule : pwcs_top
`default_nettype wire

// file: sim/pwcs_stack_model.sv
// Purpose: stack memory behind the paged call and return sequencer
// Assumes: one page pushed per call, one pulled per return
// Notes: pulled page valid only around the done cycle
`default_nettype none
module pwcs_stack_model (
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // stack traffic
    input wire logic push_valid,
    input wire logic [5:0] push_page,
    input wire logic return_start,
    output logic [5:0] return_page_pulled
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [5:0] stack [0:3];
    logic [5:0] tick;
    int sp;
    int age;
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sp <= 0;
            age <= 0;
            tick <= 6'h00;
        end else begin
            tick <= tick + 6'h25;
            if (push_valid) begin
                stack[sp[1:0]] <= push_page;
                sp <= sp + 1;
            end
            age <= return_start ? 1 : ((age == 0 || age == 4) ? 0 : age + 1);
            if (age == 4 && sp > 0) begin
                sp <= sp - 1;
            end
        end
    end
    // noise outside the load window, so a stale value cannot pass
    assign return_page_pulled = (age >= 3 && sp > 0) ? stack[2'(sp - 1)] : tick;
endmodule : pwcs_stack_model
`default_nettype wire

// file: sim/paged_window_chip_select_tb.sv
// Purpose: self-checking bench for the paged window chip select block
// Assumes: one clock, async active-low reset, stack partner model
// Notes: driver queues expected bus results, a monitor compares them
`default_nettype none
module paged_window_chip_select_tb;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {logic [5:0] xa; logic w, e, x, ce, cx, ca;} pwcs_note_t;
    pwcs_note_t notes[$];
    logic clock = 0, reset_n = 0, en = 0, exm = 0, emu = 0, wr_ok = 1, misc_write = 0;
    logic hide_d = 0, bus_valid = 0, hit = 0, unm = 0, page_write = 0, cs = 0, rs = 0;
    logic ind = 0, v_d = 0, push_valid, busy, iblk, hide, win, ecs_n, xcs_n, ovr;
    logic [1:0] sw = 2'h0, alloc = 2'h0;
    logic [15:0] addr = 16'h0000;
    logic [5:0] wdata = 6'h00, imm = 6'h00, mem = 6'h00, pg = 6'h00;
    logic [5:0] pulled, push_page, page, xa, lim;
    logic [31:0] lfsr = 32'h0001587E;
    int n_mismatch = 0, checks_done = 0, cycles = 0;
    pwcs_top dut (
        .clock(clock), .reset_n(reset_n), .port_k_expansion_enable(en),
        .expanded_mode(exm), .emulation_mode(emu), .paging_partition_switches(sw),
        .flash_allocation(alloc), .page_write_allowed(wr_ok), .misc_write(misc_write),
        .misc_rom_hide_data(hide_d), .bus_valid(bus_valid), .bus_address(addr),
        .bus_internal_hit(hit), .bus_unmapped(unm), .page_write(page_write),
        .page_write_data(wdata), .call_start(cs), .return_start(rs),
        .call_page_immediate(imm), .call_indirect(ind), .call_page_memory(mem),
        .return_page_pulled(pulled), .push_valid(push_valid), .push_page(push_page),
        .seq_busy(busy), .interrupt_block(iblk), .program_page_register(page),
        .rom_hide_in_map(hide), .page_window_access(win), .extended_address_out(xa),
        .emulation_chip_select_n(ecs_n), .external_chip_select_n(xcs_n),
        .port_k_pin_override(ovr)
    );
    pwcs_stack_model stack (
        .clock(clock), .reset_n(reset_n), .push_valid(push_valid),
        .push_page(push_page), .return_start(rs), .return_page_pulled(pulled)
    );
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : next_rand
    task automatic check(input logic [5:0] seen, input logic [5:0] want, input string what);
        checks_done++;
        if (seen !== want) begin
            n_mismatch++;
            $display("[FAIL] %0t %s seen %h want %h", $time, what, seen, want);
        end
    endtask : check
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : tally_and_finish
    task automatic set_page(input logic [5:0] p, input logic ok);
        @(negedge clock);
        bus_valid = 0; misc_write = 0; wdata = p; wr_ok = ok; page_write = 1;
        @(negedge clock);
        page_write = 0;
        if (ok) pg = p;
        check(page, pg, "page write");
    endtask : set_page
    // a plain write is held up during the sequence and must be dropped
    task automatic seq(input logic c, input logic i, input logic [5:0] v);
        logic [5:0] old;
        old = pg;
        @(negedge clock);
        cs = c; rs = !c; ind = i; imm = i ? ~v : v; mem = i ? v : ~v;
        page_write = c; wdata = 6'h3F; wr_ok = 1;
        for (int k = 1; k <= 5; k++) begin
            @(negedge clock);
            cs = 0; rs = 0; page_write = (k == 2);
            check(6'({busy, iblk}), (k < 4) ? 6'h03 : 6'h00, "busy");
            check(6'(push_valid), 6'(c && k == 2), "push");
            if (c && k == 2) check(push_page, old, "pushed");
            check(page, (c || k >= 4) ? v : old, "seq page");
        end
        pg = v;
    endtask : seq
    task automatic access(input logic [15:0] a, input logic m, e, h, u);
        pwcs_note_t n;
        logic ext, fl, on;
        logic [1:0] q;
        q = a[15:14];
        lim = (sw == 2'h0) ? 6'h37 : (sw == 2'h1) ? 6'h2F : 6'h1F;
        ext = (sw != 2'h3) && (pg <= lim);
        case (alloc)
            2'h0: fl = q[1];
            2'h1: fl = (q == 2'h3);
            2'h2: fl = (q == 2'h3) || (q == 2'h1 && !hide_d) || (q == 2'h2 && !ext);
            default: fl = (q == 2'h3) || (!q[1] && !hide_d) || (q == 2'h2 && !ext);
        endcase
        on = e && exm && m && fl;
        n.xa = (q == 2'h2) ? pg : 6'h3D + {4'h0, (q == 2'h3) ? 2'h2 : q};
        n.w = (q == 2'h2);
        n.e = !on;
        n.x = on || h || u;
        n.ce = !h && !u;
        n.cx = e && exm && (on || h || u || q != 2'h2 || ext);
        n.ca = e && exm;
        @(negedge clock);
        addr = a; emu = m; en = e; hit = h; unm = u; bus_valid = 1;
        notes.push_back(n);
        #1;
        check(6'(ovr), 6'(e && exm), "override");
    endtask : access
    ////////////////////////////////////////////////////////////////////////////////
    always #50 clock = ~clock;
    always @(posedge clock) begin
        cycles++;
        if (cycles == 2000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end
    always @(posedge clock) v_d <= bus_valid;
    always @(negedge clock) begin
        pwcs_note_t n;
        if (v_d && notes.size() > 0) begin
            n = notes.pop_front();
            check(6'(win), 6'(n.w), "window");
            if (n.ca) check(xa, n.xa, "xaddr");
            if (n.ce) check(6'(ecs_n), 6'(n.e), "emu sel");
            if (n.cx) check(6'(xcs_n), 6'(n.x), "ext sel");
        end
    end
    initial begin
        repeat (8) @(posedge clock);
        @(negedge clock);
        reset_n = 1;
        exm = 1;
        set_page(6'h05, 1'b1);
        set_page(6'h2A, 1'b0);
        seq(1'b1, 1'b0, 6'h11);
        seq(1'b1, 1'b1, 6'h33);
        seq(1'b0, 1'b0, 6'h11);
        seq(1'b0, 1'b0, 6'h05);
        for (int al = 0; al < 8; al++) begin
            repeat (7) lfsr = next_rand(lfsr);
            @(negedge clock);
            bus_valid = 0; alloc = 2'(al / 2); sw = lfsr[1:0]; hide_d = al[0]; misc_write = 1;
            set_page(lfsr[9:4], 1'b1);
            check(6'(hide), 6'(hide_d), "rom hide");
            for (int q = 0; q < 8; q++) access({q[1:0], lfsr[23:10]}, q[2], 1'b1, 1'b0, 1'b0);
        end
        // partition limits, both sides of each boundary
        for (int s = 0; s < 8; s++) begin
            // modes move only after the previous access has been sampled
            @(negedge clock);
            bus_valid = 0;
            alloc = 2'h2;
            sw = 2'(s / 2);
            lim = (sw == 2'h0) ? 6'h37 : (sw == 2'h1) ? 6'h2F : (sw == 2'h2) ? 6'h1F : 6'h3F;
            set_page(lim + 6'(s % 2), 1'b1);
            access(16'h8000, 1'b1, 1'b1, 1'b0, 1'b0);
        end
        access(16'h1234, 1'b0, 1'b1, 1'b1, 1'b0);
        access(16'h0010, 1'b1, 1'b1, 1'b0, 1'b1);
        access(16'hC000, 1'b1, 1'b0, 1'b0, 1'b0);
        @(negedge clock);
        bus_valid = 0;
        exm = 0;
        access(16'hC000, 1'b1, 1'b1, 1'b0, 1'b0);
        @(negedge clock);
        bus_valid = 0;
        repeat (2) @(negedge clock);
        tally_and_finish();
    end
endmodule : paged_window_chip_select_tb
`default_nettype wire
